// ===== tickt_top.sv
// Purpose: tick timer wrap value and running count with AXI4-Lite registers
// Assumes: one clock aclk at 100 MHz, synchronous active-low reset
// Notes: unmapped addresses answer SLVERR; irq is a level
//
// Overview of operation
// - A wrap value of 0 is accepted but gives no tick events, since events need a step from 1 to 0.
// - The tick pulse rises on the clock where the count steps from 1 to 0; the count-reached flag and tick request rise one clock later.
// - With a fixed wrap value N one tick occurs every N+1 count pulses.
// - The wrap value sits in bits 23:0 and is moved into the running count at zero.
// - Bits 31:24 of both registers are read-only reserved; software keeps them on read-modify-write.
// - Reading the running count returns in bits 23:0 the value at the moment of access.
// - Any write to the running count forces it to 0 whatever the data.
// - Clearing the running count by a write also clears the count-reached flag.
// - There is no calibration value register.
// - While enabled the count decrements to zero, reloads on the next edge, then decrements on.
// - The count-reached flag at bit 16 reads 1 if zero was reached since the last read, and a read clears it.
// - With tick interrupt enable at bit 1 set, reaching zero pends the tick request; clear, no request.
// - The count does not decrement while the core is halted in debug state.
`timescale 1ns/1ns
`default_nettype none
module tickt_top (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [tickt_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [tickt_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [tickt_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [tickt_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // core status and reference
    input wire logic core_halted,
    input wire logic ext_ref_clk,
    // events
    output logic tick_pulse,
    output logic tick_irq
);
    tickt_count_if cif ();

    // write channel holding state
    logic aw_held_reg;
    logic w_held_reg;
    logic [tickt_pkg::ADDR_W-1:0] aw_addr_reg;
    logic [tickt_pkg::DATA_W-1:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    // read channel state
    logic rvalid_reg;
    logic [tickt_pkg::DATA_W-1:0] rdata_reg;
    logic [1:0] rresp_reg;

    // software state
    logic enable_reg;
    logic irq_en_reg;
    logic clk_sel_reg;
    logic flag_reg;
    logic [tickt_pkg::COUNT_W-1:0] wrap_reg;
    logic istat_reg;
    logic imask_reg;
    logic irq_reg;

    logic wr_fire;
    logic rd_fire;
    logic ref_rise;
    tickt_pkg::tickt_sel_t wr_sel;
    tickt_pkg::tickt_sel_t rd_sel;
    logic [tickt_pkg::DATA_W-1:0] rd_value;
    logic [tickt_pkg::DATA_W-1:0] wr_merged_ctrl;
    logic [tickt_pkg::DATA_W-1:0] wr_merged_wrap;

    function automatic tickt_pkg::tickt_sel_t decode_sel(input logic [tickt_pkg::ADDR_W-1:0] addr);
        tickt_pkg::tickt_sel_t sel;
        sel = tickt_pkg::SEL_NONE;
        if (addr == tickt_pkg::OFS_CTRL) begin
            sel = tickt_pkg::SEL_CTRL;
        end else if (addr == tickt_pkg::OFS_WRAP) begin
            sel = tickt_pkg::SEL_WRAP;
        end else if (addr == tickt_pkg::OFS_COUNT) begin
            sel = tickt_pkg::SEL_COUNT;
        end else if (addr == tickt_pkg::OFS_ISTAT) begin
            sel = tickt_pkg::SEL_ISTAT;
        end else if (addr == tickt_pkg::OFS_IMASK) begin
            sel = tickt_pkg::SEL_IMASK;
        end
        // calibration has no slot, so it falls to SEL_NONE
        return sel;
    endfunction

    function automatic logic [tickt_pkg::DATA_W-1:0] merge_lanes(
        input logic [tickt_pkg::DATA_W-1:0] old_val,
        input logic [tickt_pkg::DATA_W-1:0] new_val,
        input logic [3:0] strb
    );
        logic [tickt_pkg::DATA_W-1:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // bus handshakes
    assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
    assign s_axi_wready = ~w_held_reg & ~bvalid_reg;
    assign s_axi_arready = ~rvalid_reg;
    assign wr_fire = aw_held_reg & w_held_reg & ~bvalid_reg;
    assign rd_fire = s_axi_arvalid & s_axi_arready;
    assign wr_sel = decode_sel(aw_addr_reg);
    assign rd_sel = decode_sel(s_axi_araddr);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg <= 1'b0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= tickt_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= (wr_sel == tickt_pkg::SEL_NONE) ? tickt_pkg::RESP_SLVERR : tickt_pkg::RESP_OKAY;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // read value mux, reserved bits read as zero
    always_comb begin
        rd_value = tickt_pkg::RD_ZERO;
        case (rd_sel)
            tickt_pkg::SEL_CTRL: begin
                rd_value[tickt_pkg::BIT_ENABLE] = enable_reg;
                rd_value[tickt_pkg::BIT_IRQ_EN] = irq_en_reg;
                rd_value[tickt_pkg::BIT_CLK_SEL] = clk_sel_reg;
                rd_value[tickt_pkg::BIT_FLAG] = flag_reg;
            end
            tickt_pkg::SEL_WRAP: begin
                rd_value[tickt_pkg::COUNT_W-1:0] = wrap_reg;
            end
            tickt_pkg::SEL_COUNT: begin
                rd_value[tickt_pkg::COUNT_W-1:0] = cif.count;
            end
            tickt_pkg::SEL_ISTAT: begin
                rd_value[tickt_pkg::BIT_IRQ_TICK] = istat_reg;
            end
            tickt_pkg::SEL_IMASK: begin
                rd_value[tickt_pkg::BIT_IRQ_TICK] = imask_reg;
            end
            default: begin
                rd_value = tickt_pkg::RD_ZERO;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= tickt_pkg::RD_ZERO;
            rresp_reg <= tickt_pkg::RESP_OKAY;
        end else if (rd_fire) begin
            // sampled at the address edge, so the count is that of the access
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_value;
            rresp_reg <= (rd_sel == tickt_pkg::SEL_NONE) ? tickt_pkg::RESP_SLVERR : tickt_pkg::RESP_OKAY;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // the image function reads module state, which an assign would not wake on
    always_comb begin
        wr_merged_ctrl = merge_lanes(rd_ctrl_image(), w_data_reg, w_strb_reg);
    end
    assign wr_merged_wrap = merge_lanes({8'h00, wrap_reg}, w_data_reg, w_strb_reg);

    function automatic logic [tickt_pkg::DATA_W-1:0] rd_ctrl_image();
        logic [tickt_pkg::DATA_W-1:0] img;
        img = tickt_pkg::RD_ZERO;
        img[tickt_pkg::BIT_ENABLE] = enable_reg;
        img[tickt_pkg::BIT_IRQ_EN] = irq_en_reg;
        img[tickt_pkg::BIT_CLK_SEL] = clk_sel_reg;
        return img;
    endfunction

    // control bits; the flag is not writable here
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable_reg <= 1'b0;
            irq_en_reg <= 1'b0;
            clk_sel_reg <= 1'b0;
        end else if (wr_fire && wr_sel == tickt_pkg::SEL_CTRL) begin
            enable_reg <= wr_merged_ctrl[tickt_pkg::BIT_ENABLE];
            irq_en_reg <= wr_merged_ctrl[tickt_pkg::BIT_IRQ_EN];
            clk_sel_reg <= wr_merged_ctrl[tickt_pkg::BIT_CLK_SEL];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wrap_reg <= tickt_pkg::RST_WRAP;
        end else if (wr_fire && wr_sel == tickt_pkg::SEL_WRAP) begin
            // upper byte is dropped: reserved bits stay read-only
            wrap_reg <= wr_merged_wrap[tickt_pkg::COUNT_W-1:0];
        end
    end

    // flag: a new zero wins over a clearing read or write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_reg <= 1'b0;
        end else if (cif.zero_event) begin
            flag_reg <= 1'b1;
        end else if (rd_fire && rd_sel == tickt_pkg::SEL_CTRL) begin
            flag_reg <= 1'b0;
        end else if (wr_fire && wr_sel == tickt_pkg::SEL_COUNT) begin
            flag_reg <= 1'b0;
        end
    end

    // sticky tick status, only while the tick interrupt is enabled
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            istat_reg <= 1'b0;
        end else if (cif.zero_event && irq_en_reg) begin
            istat_reg <= 1'b1;
        end else if (rd_fire && rd_sel == tickt_pkg::SEL_ISTAT) begin
            istat_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            imask_reg <= 1'b0;
        end else if (wr_fire && wr_sel == tickt_pkg::SEL_IMASK && w_strb_reg[0]) begin
            imask_reg <= w_data_reg[tickt_pkg::BIT_IRQ_TICK];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= istat_reg & imask_reg;
        end
    end

    // external reference path; clk_sel_reg resets to 0, so the reference is the default choice
    tickt_ref_edge u_ref_edge (
        .aclk(aclk),
        .aresetn(aresetn),
        .ref_pin(ext_ref_clk),
        .ref_rise(ref_rise)
    );

    assign cif.step = enable_reg & ~core_halted & (clk_sel_reg | ref_rise);
    assign cif.clear = wr_fire & (wr_sel == tickt_pkg::SEL_COUNT);
    assign cif.wrap = wrap_reg;

    tickt_count_core u_core (
        .aclk(aclk),
        .aresetn(aresetn),
        .cif(cif)
    );

    // outputs
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign tick_pulse = cif.zero_event;
    assign tick_irq = irq_reg;
endmodule
`default_nettype wire

// ===== tickt_pkg.sv
// Purpose: shared constants and types of the tick timer wrap/count block
// Assumes: 32-bit AXI4-Lite register bus, 24-bit down counter
// Notes: register offsets are byte addresses, one aligned word each
package tickt_pkg;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned COUNT_W = 24;

    // register map
    localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_WRAP = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_COUNT = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_ISTAT = 12'h00c;
    localparam logic [ADDR_W-1:0] OFS_IMASK = 12'h010;

    // control and status fields
    localparam int unsigned BIT_ENABLE = 0;
    localparam int unsigned BIT_IRQ_EN = 1;
    localparam int unsigned BIT_CLK_SEL = 2;
    localparam int unsigned BIT_FLAG = 16;

    // interrupt status and mask fields
    localparam int unsigned BIT_IRQ_TICK = 0;

    // reset values and counter constants
    localparam logic [COUNT_W-1:0] RST_WRAP = 24'h000000;
    localparam logic [COUNT_W-1:0] RST_COUNT = 24'h000000;
    localparam logic [COUNT_W-1:0] COUNT_ONE = 24'h000001;
    localparam logic [DATA_W-1:0] RD_ZERO = 32'h00000000;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        SEL_CTRL,
        SEL_WRAP,
        SEL_COUNT,
        SEL_ISTAT,
        SEL_IMASK,
        SEL_NONE
    } tickt_sel_t;
endpackage

// ===== tickt_count_if.sv
// Purpose: carrier between the register top and the down-counter core
// Assumes: single clock domain
// Notes: core modport drives count and event
`timescale 1ns/1ns
`default_nettype none
interface tickt_count_if;
    logic step;
    logic clear;
    logic [tickt_pkg::COUNT_W-1:0] wrap;
    logic [tickt_pkg::COUNT_W-1:0] count;
    logic zero_event;

    modport core (input step, input clear, input wrap, output count, output zero_event);
    modport ctrl (output step, output clear, output wrap, input count, input zero_event);
endinterface
`default_nettype wire

// ===== tickt_ref_edge.sv
// Purpose: bring the external reference tick pin into aclk and find its rising edges
// Assumes: reference at least 2.5 times slower than aclk
// Notes: first flop feeds only the second
`timescale 1ns/1ns
`default_nettype none
module tickt_ref_edge (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // pin and edge
    input wire logic ref_pin,
    output logic ref_rise
);
    logic sync1_reg;
    logic sync2_reg;
    logic prev_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            prev_reg <= 1'b0;
        end else begin
            sync1_reg <= ref_pin;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    assign ref_rise = sync2_reg & ~prev_reg;
endmodule
`default_nettype wire

// ===== tickt_count_core.sv
// Purpose: 24-bit down counter with wrap reload and zero event
// Assumes: step is one-cycle qualified count pulse
// Notes: clear wins over step; zero_event is registered
`timescale 1ns/1ns
`default_nettype none
module tickt_count_core (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control side
    tickt_count_if.core cif
);
    logic [tickt_pkg::COUNT_W-1:0] count_reg;
    logic zero_event_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_reg <= tickt_pkg::RST_COUNT;
        end else if (cif.clear) begin
            count_reg <= tickt_pkg::RST_COUNT;
        end else if (cif.step) begin
            if (count_reg == tickt_pkg::RST_COUNT) begin
                // a zero wrap keeps the count parked at zero, so no events
                count_reg <= cif.wrap;
            end else begin
                count_reg <= count_reg - tickt_pkg::COUNT_ONE;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            zero_event_reg <= 1'b0;
        end else begin
            // only the 1 to 0 step counts, a forced clear does not
            zero_event_reg <= cif.step & ~cif.clear & (count_reg == tickt_pkg::COUNT_ONE);
        end
    end

    assign cif.count = count_reg;
    assign cif.zero_event = zero_event_reg;
endmodule
`default_nettype wire

// ===== tickt_sva.sv
// Purpose: bus answer and tick timing checks on the tick timer top
// Assumes: sees only the ports of tickt_top, one clock domain
// Notes: bind sits at the foot of this file
`timescale 1ns/1ns
`default_nettype none
module tickt_sva (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [tickt_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [tickt_pkg::DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    // timer
    input wire logic core_halted,
    input wire logic tick_pulse,
    input wire logic tick_irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_HALT_NO_TICK: assert property (tick_pulse |-> !$past(core_halted))
        else $error("tick seen after a halted cycle");
    AST_TICK_GAP: assert property (tick_pulse |=> !tick_pulse)
        else $error("tick pulses back to back");
    AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_RD_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while answer pending");
    AST_NO_CALIB: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h014 |=>
        s_axi_rresp == tickt_pkg::RESP_SLVERR && s_axi_rdata == tickt_pkg::RD_ZERO)
        else $error("calibration slot answered");
    AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |->
        ##2 s_axi_bvalid)
        else $error("write answer not two cycles after handshake");
    AST_WR_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    AST_IRQ_CAUSE: assert property ($rose(tick_irq) |->
        $past(tick_pulse) || $past(tick_pulse, 2) || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
        else $error("interrupt rose without a tick or a write");
endmodule

bind tickt_top tickt_sva u_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .core_halted, .tick_pulse, .tick_irq);
`default_nettype wire

// ===== testbench.sv
// Purpose: self-checking bench for the tick timer top
// Assumes: 100 MHz aclk, registers over AXI4-Lite
// Notes: wrap values in the tick tests kept small so tick periods stay short
`timescale 1ns/1ns
`default_nettype none
`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin num_errors++; \
    $display("unexpected %s expected %0h seen %0h", what, exp, got); end end
module testbench;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, rd_data;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, tick_pulse, tick_irq;
    logic [1:0] bresp, rresp, resp;
    logic halted = 1'b0, ext_ref = 1'b0, ext_run = 1'b0;
    logic [3:0] wstrb = 4'hf;
    int num_errors = 0, checks = 0, cyc = 0, pulses = 0, gap = 0, last = 0;

    always #5 aclk = !aclk;

    tickt_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .core_halted(halted), .ext_ref_clk(ext_ref), .tick_pulse(tick_pulse),
        .tick_irq(tick_irq));

    // ref pin period is 8 aclk cycles, well inside the 2.5x limit
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (tick_pulse === 1'b1) begin
            pulses <= pulses + 1;
            gap <= cyc - last;
            last <= cyc;
        end
        if (ext_run && cyc[1:0] == 2'd3) ext_ref <= !ext_ref;
    end

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && awready === 1'b1) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready === 1'b1) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rd_data = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    task automatic wait_tick(input int m);
        int p;
        p = pulses;
        while (pulses < p + m) @(posedge aclk);
    endtask

    function automatic logic [31:0] ctrl_val(input logic en, input logic ie, input logic sel);
        ctrl_val = '0;
        ctrl_val[tickt_pkg::BIT_ENABLE] = en;
        ctrl_val[tickt_pkg::BIT_IRQ_EN] = ie;
        ctrl_val[tickt_pkg::BIT_CLK_SEL] = sel;
    endfunction

    function automatic int exp_gap(input int wrap, input int div);
        return (wrap + 1) * div;
    endfunction

    task automatic close_out;
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        #200000;
        num_errors++;
        close_out();
    end

    initial begin
        logic [23:0] n;
        logic [31:0] c1;
        void'($urandom(56722));
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(tickt_pkg::OFS_WRAP);
        `CHK("wrap reset", 32'h0, rd_data)
        rd(tickt_pkg::OFS_COUNT);
        `CHK("count reset", 32'h0, rd_data)
        rd(12'h014);
        `CHK("calib resp", tickt_pkg::RESP_SLVERR, resp)
        `CHK("calib data", tickt_pkg::RD_ZERO, rd_data)
        wr(12'h014, $urandom);
        `CHK("calib wresp", tickt_pkg::RESP_SLVERR, resp)
        wr(tickt_pkg::OFS_WRAP, 32'hffffffff);
        rd(tickt_pkg::OFS_WRAP);
        `CHK("wrap reserved", 32'h00ffffff, rd_data)
        // large random wrap so two reads never straddle a reload
        n = 24'($urandom_range(24'hffffff, 24'h001000));
        wr(tickt_pkg::OFS_WRAP, {8'ha5, n});
        `CHK("wrap wresp", tickt_pkg::RESP_OKAY, resp)
        rd(tickt_pkg::OFS_WRAP);
        `CHK("wrap value", {8'h00, n}, rd_data)
        `CHK("wrap rresp", tickt_pkg::RESP_OKAY, resp)
        // low byte lane only: the upper wrap bytes must survive
        c1 = $urandom;
        wstrb <= 4'h1;
        wr(tickt_pkg::OFS_WRAP, c1);
        wstrb <= 4'hf;
        n[7:0] = c1[7:0];
        rd(tickt_pkg::OFS_WRAP);
        `CHK("wrap strobe", {8'h00, n}, rd_data)
        wr(tickt_pkg::OFS_CTRL, ctrl_val(1'b1, 1'b0, 1'b1));
        rd(tickt_pkg::OFS_COUNT);
        c1 = rd_data;
        rd(tickt_pkg::OFS_COUNT);
        `CHK("count in range", 1'b1, c1[23:0] <= n)
        `CHK("count falls", 1'b1, rd_data[23:0] < c1[23:0])
        `CHK("count reserved", 8'h00, rd_data[31:24])
        wr(tickt_pkg::OFS_CTRL, 32'h0);
        // count is only ever cleared by a plain write, never read-modify-write
        wr(tickt_pkg::OFS_COUNT, $urandom);
        rd(tickt_pkg::OFS_COUNT);
        `CHK("count cleared", 32'h0, rd_data)
        wr(tickt_pkg::OFS_IMASK, 32'h1);
        for (int k = 0; k < 3; k++) begin
            n = (k < 2) ? 24'(k + 1) : 24'($urandom_range(9, 3));
            wr(tickt_pkg::OFS_WRAP, {8'h00, n});
            wr(tickt_pkg::OFS_CTRL, ctrl_val(1'b1, 1'b1, 1'b1));
            wait_tick(2);
            `CHK("tick period", exp_gap(n, 1), gap)
            wr(tickt_pkg::OFS_CTRL, 32'h0);
            `CHK("irq raised", 1'b1, tick_irq)
            rd(tickt_pkg::OFS_CTRL);
            `CHK("flag set", 1'b1, rd_data[tickt_pkg::BIT_FLAG])
            rd(tickt_pkg::OFS_CTRL);
            `CHK("flag read clear", 1'b0, rd_data[tickt_pkg::BIT_FLAG])
            rd(tickt_pkg::OFS_ISTAT);
            `CHK("istat set", 32'h1, rd_data)
            repeat (3) @(posedge aclk);
            `CHK("irq cleared", 1'b0, tick_irq)
        end
        // external reference: 8 aclk cycles per step
        ext_run <= 1'b1;
        wr(tickt_pkg::OFS_CTRL, ctrl_val(1'b1, 1'b0, 1'b0));
        wait_tick(2);
        `CHK("ref period", exp_gap(n, 8), gap)
        wr(tickt_pkg::OFS_CTRL, 32'h0);
        rd(tickt_pkg::OFS_ISTAT);
        `CHK("istat gated", 32'h0, rd_data)
        wr(tickt_pkg::OFS_COUNT, $urandom);
        rd(tickt_pkg::OFS_CTRL);
        `CHK("flag write clear", 1'b0, rd_data[tickt_pkg::BIT_FLAG])
        wr(tickt_pkg::OFS_IMASK, 32'h0);
        wr(tickt_pkg::OFS_CTRL, ctrl_val(1'b1, 1'b1, 1'b1));
        wait_tick(1);
        halted <= 1'b1;
        c1 = pulses;
        repeat (40) @(posedge aclk);
        `CHK("halted ticks", c1, pulses)
        `CHK("irq masked", 1'b0, tick_irq)
        wr(tickt_pkg::OFS_IMASK, 32'h1);
        repeat (3) @(posedge aclk);
        `CHK("irq unmasked", 1'b1, tick_irq)
        halted <= 1'b0;
        wr(tickt_pkg::OFS_WRAP, 32'h0);
        wait_tick(1);
        wr(tickt_pkg::OFS_COUNT, 32'h0);
        c1 = pulses;
        repeat (40) @(posedge aclk);
        `CHK("zero wrap ticks", c1, pulses)
        close_out();
    end
endmodule
`default_nettype wire
